// *** hw/tcpc_cfg.svh ***
// Constants of the timing core phase configuration registers
`ifndef TCPC_CFG_SVH
`define TCPC_CFG_SVH

// ***************************************************************
// Register addresses
// ***************************************************************
`define TCPC_ADDR_DRIVE_A   8'h35
`define TCPC_ADDR_DRIVE_B   8'h36
`define TCPC_ADDR_CDS       8'h37
`define TCPC_ADDR_OUTPHASE  8'h38
`define TCPC_ADDR_HMASK     8'h39
`define TCPC_TEST1_LO       8'h3e
`define TCPC_TEST1_HI       8'h4f
`define TCPC_TEST2_LO       8'h50
`define TCPC_TEST2_HI       8'h6f

// ***************************************************************
// Field positions
// ***************************************************************
`define TCPC_F_DRV1         2:0
`define TCPC_F_DRV2         6:4
`define TCPC_F_DRV3         10:8
`define TCPC_F_DRV4         14:12
`define TCPC_F_DRVLAST      18:16
`define TCPC_F_DRVGATE      22:20
`define TCPC_F_DRV5         2:0
`define TCPC_F_DRV6         6:4
`define TCPC_F_DRV7         10:8
`define TCPC_F_DRV8         14:12
`define TCPC_F_DATAEDGE     5:0
`define TCPC_F_RSTEDGE      11:6
`define TCPC_F_RSTWIDTH     17:12
`define TCPC_F_PHRISE       5:0
`define TCPC_F_PHFALL       11:6
`define TCPC_B_TRACK        12
`define TCPC_F_DELAY        14:13
`define TCPC_B_INVERT       15
`define TCPC_F_HMASK        2:0

// ***************************************************************
// Widths, reset values, serial frame
// ***************************************************************
`define TCPC_W_DRIVE_A      23
`define TCPC_W_DRIVE_B      15
`define TCPC_W_CDS          18
`define TCPC_W_OUTPHASE     16
`define TCPC_W_HMASK        3
`define TCPC_RST_DRIVE_A    23'h111111
`define TCPC_RST_DRIVE_B    15'h1111
`define TCPC_RST_CDS        18'h0a500
`define TCPC_RST_OUTPHASE   16'h0500
`define TCPC_RST_HMASK      3'h7
`define TCPC_ADDR_BITS      6'h08
`define TCPC_FRAME_BITS     6'h24
`define TCPC_DATA_BITS      28
`define TCPC_FIXED_PHASE    6'h00

`endif

// *** hw/tcpc_pkg.sv ***
// Types of the timing core phase configuration registers
`default_nettype none
package tcpc_pkg;
   typedef enum logic {SER_IDLE, SER_SHIFT} tcpc_ser_e;
   typedef logic [7:0] tcpc_addr_t;
endpackage
`default_nettype wire

// *** hw/tcpc_phase_config.sv ***
// Timing core phase configuration register set with serial write port
`timescale 1ns/10ps
`default_nettype none
`include "tcpc_cfg.svh"

module tcpc_phase_config
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Serial write port
   input  wire logic        serialLoad_n,
   input  wire logic        serialClock,
   input  wire logic        serialData,
   // Drive strength codes
   output logic [2:0]       first_horiz_drive,
   output logic [2:0]       second_horiz_drive,
   output logic [2:0]       third_horiz_drive,
   output logic [2:0]       fourth_horiz_drive,
   output logic [2:0]       last_horiz_drive,
   output logic [2:0]       reset_gate_drive,
   output logic [2:0]       fifth_horiz_drive,
   output logic [2:0]       sixth_horiz_drive,
   output logic [2:0]       seventh_horiz_drive,
   output logic [2:0]       eighth_horiz_drive,
   // Sampling control
   output logic [5:0]       data_sample_edge_pos,
   output logic [5:0]       reset_sample_edge_pos,
   output logic [5:0]       reset_sample_width,
   // Output stage control
   output logic [5:0]       out_phase_rise,
   output logic [5:0]       out_phase_fall,
   output logic             data_clock_track_select,
   output logic [1:0]       out_data_delay_sel,
   output logic             data_clock_invert,
   output logic [5:0]       dataClockPhase,
   // Clamp masking and write status
   output logic [2:0]       clamp_horiz_mask_en,
   output logic             writeDone
);

   // ***************************************************************
   // Serial frame capture
   // ***************************************************************
   tcpc_pkg::tcpc_ser_e                 serState;
   tcpc_pkg::tcpc_ser_e                 next_serState;
   logic                                sckPrev;
   logic                                loadPrev;
   logic [5:0]                          bitCnt;
   logic [5:0]                          next_bitCnt;
   tcpc_pkg::tcpc_addr_t                addrSr;
   tcpc_pkg::tcpc_addr_t                next_addrSr;
   logic [`TCPC_DATA_BITS-1:0]          dataSr;
   logic [`TCPC_DATA_BITS-1:0]          next_dataSr;
   logic                                sckRise;
   logic                                loadRise;
   logic                                commit;

   assign sckRise  = serialClock & ~sckPrev;
   assign loadRise = serialLoad_n & ~loadPrev;
   assign commit   = (serState == tcpc_pkg::SER_SHIFT) && loadRise
                     && (bitCnt >= `TCPC_ADDR_BITS);

   always_comb
   begin
      next_serState = serState;
      next_bitCnt   = bitCnt;
      next_addrSr   = addrSr;
      next_dataSr   = dataSr;
      unique case (serState)
         tcpc_pkg::SER_IDLE:
         begin
            if (!serialLoad_n)
            begin
               next_serState = tcpc_pkg::SER_SHIFT;
               next_bitCnt   = 6'h00;
               next_addrSr   = 8'h00;
               next_dataSr   = '0;
            end
         end
         tcpc_pkg::SER_SHIFT:
         begin
            if (serialLoad_n)
               next_serState = tcpc_pkg::SER_IDLE;
            else if (sckRise && bitCnt < `TCPC_FRAME_BITS)
            begin
               // Address first, then data, both LSB first
               if (bitCnt < `TCPC_ADDR_BITS)
                  next_addrSr[bitCnt[2:0]] = serialData;
               else
                  next_dataSr[5'(bitCnt - `TCPC_ADDR_BITS)] = serialData;
               next_bitCnt = bitCnt + 6'h01;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         serState <= tcpc_pkg::SER_IDLE;
         sckPrev  <= 1'b0;
         loadPrev <= 1'b1;
         bitCnt   <= 6'h00;
         addrSr   <= 8'h00;
         dataSr   <= '0;
      end
      else
      begin
         serState <= next_serState;
         sckPrev  <= serialClock;
         loadPrev <= serialLoad_n;
         bitCnt   <= next_bitCnt;
         addrSr   <= next_addrSr;
         dataSr   <= next_dataSr;
      end
   end

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   logic [`TCPC_W_DRIVE_A-1:0]   driveA, next_driveA;
   logic [`TCPC_W_DRIVE_B-1:0]   driveB, next_driveB;
   logic [`TCPC_W_CDS-1:0]       cdsPhase, next_cdsPhase;
   logic [`TCPC_W_OUTPHASE-1:0]  outPhase, next_outPhase;
   logic [`TCPC_W_HMASK-1:0]     hMask, next_hMask;
   logic                         next_writeDone;
   logic [5:0]                   next_dataClockPhase;

   // Test ranges fall through the decode, so writes there are dropped
   always_comb
   begin
      next_driveA    = driveA;
      next_driveB    = driveB;
      next_cdsPhase  = cdsPhase;
      next_outPhase  = outPhase;
      next_hMask     = hMask;
      next_writeDone = 1'b0;
      if (commit)
      begin
         unique case (addrSr)
            `TCPC_ADDR_DRIVE_A:
            begin
               next_driveA    = dataSr[`TCPC_W_DRIVE_A-1:0];
               next_writeDone = 1'b1;
            end
            `TCPC_ADDR_DRIVE_B:
            begin
               next_driveB    = dataSr[`TCPC_W_DRIVE_B-1:0];
               next_writeDone = 1'b1;
            end
            `TCPC_ADDR_CDS:
            begin
               next_cdsPhase  = dataSr[`TCPC_W_CDS-1:0];
               next_writeDone = 1'b1;
            end
            `TCPC_ADDR_OUTPHASE:
            begin
               next_outPhase  = dataSr[`TCPC_W_OUTPHASE-1:0];
               next_writeDone = 1'b1;
            end
            `TCPC_ADDR_HMASK:
            begin
               next_hMask     = dataSr[`TCPC_W_HMASK-1:0];
               next_writeDone = 1'b1;
            end
            default:
               next_writeDone = 1'b0;
         endcase
      end
      // Clock phase follows the rising phase, or is forced to TCPC_FIXED_PHASE when track is set
      if (next_outPhase[`TCPC_B_TRACK])
         next_dataClockPhase = `TCPC_FIXED_PHASE;
      else
         next_dataClockPhase = next_outPhase[`TCPC_F_PHRISE];
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         driveA         <= `TCPC_RST_DRIVE_A;
         driveB         <= `TCPC_RST_DRIVE_B;
         cdsPhase       <= `TCPC_RST_CDS;
         outPhase       <= `TCPC_RST_OUTPHASE;
         hMask          <= `TCPC_RST_HMASK;
         writeDone      <= 1'b0;
         dataClockPhase <= `TCPC_FIXED_PHASE;
      end
      else
      begin
         driveA         <= next_driveA;
         driveB         <= next_driveB;
         cdsPhase       <= next_cdsPhase;
         outPhase       <= next_outPhase;
         hMask          <= next_hMask;
         writeDone      <= next_writeDone;
         dataClockPhase <= next_dataClockPhase;
      end
   end

   // ***************************************************************
   // Field outputs
   // ***************************************************************
   assign first_horiz_drive       = driveA[`TCPC_F_DRV1];
   assign second_horiz_drive      = driveA[`TCPC_F_DRV2];
   assign third_horiz_drive       = driveA[`TCPC_F_DRV3];
   assign fourth_horiz_drive      = driveA[`TCPC_F_DRV4];
   assign last_horiz_drive        = driveA[`TCPC_F_DRVLAST];
   assign reset_gate_drive        = driveA[`TCPC_F_DRVGATE];
   assign fifth_horiz_drive       = driveB[`TCPC_F_DRV5];
   assign sixth_horiz_drive       = driveB[`TCPC_F_DRV6];
   assign seventh_horiz_drive     = driveB[`TCPC_F_DRV7];
   assign eighth_horiz_drive      = driveB[`TCPC_F_DRV8];
   assign data_sample_edge_pos    = cdsPhase[`TCPC_F_DATAEDGE];
   assign reset_sample_edge_pos   = cdsPhase[`TCPC_F_RSTEDGE];
   assign reset_sample_width      = cdsPhase[`TCPC_F_RSTWIDTH];
   assign out_phase_rise          = outPhase[`TCPC_F_PHRISE];
   // Stored as written; duty cycle relies on software
   assign out_phase_fall          = outPhase[`TCPC_F_PHFALL];
   assign data_clock_track_select = outPhase[`TCPC_B_TRACK];
   assign out_data_delay_sel      = outPhase[`TCPC_F_DELAY];
   assign data_clock_invert       = outPhase[`TCPC_B_INVERT];
   assign clamp_horiz_mask_en     = hMask;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_RESET_DEFAULTS: assert property ($past(reset) |->
      driveA == `TCPC_RST_DRIVE_A && driveB == `TCPC_RST_DRIVE_B
      && hMask == `TCPC_RST_HMASK)
      else $error("Drive or mask defaults wrong after reset");
   AST_CDS_DEFAULTS: assert property ($past(reset) |->
      data_sample_edge_pos == 6'h00 && reset_sample_edge_pos == 6'h14
      && reset_sample_width == 6'h0a && out_phase_rise == 6'h00)
      else $error("Sample or phase defaults wrong after reset");
   AST_DRIVE_A_WRITE: assert property (commit
      && addrSr == `TCPC_ADDR_DRIVE_A |=> first_horiz_drive == $past(dataSr[2:0])
      && reset_gate_drive == $past(dataSr[22:20])
      && last_horiz_drive == $past(dataSr[18:16]))
      else $error("First drive register not written");
   AST_MASK_WRITE: assert property (commit
      && addrSr == `TCPC_ADDR_HMASK |=> clamp_horiz_mask_en == $past(dataSr[2:0]))
      else $error("Mask register not written");
   AST_SHORT_FRAME: assert property ($rose(serialLoad_n)
      && serState == tcpc_pkg::SER_SHIFT && bitCnt < `TCPC_ADDR_BITS |=> !writeDone
      && $stable(driveA) && $stable(driveB) && $stable(hMask))
      else $error("Short frame changed a register");
   AST_DRIVE_B_WRITE: assert property (commit
      && addrSr == `TCPC_ADDR_DRIVE_B |=> fifth_horiz_drive == $past(dataSr[2:0])
      && eighth_horiz_drive == $past(dataSr[14:12]))
      else $error("Second drive register not written");
   AST_CDS_WRITE: assert property (commit
      && addrSr == `TCPC_ADDR_CDS |=> reset_sample_width == $past(dataSr[17:12])
      && data_sample_edge_pos == $past(dataSr[5:0]))
      else $error("Sample register not written");
   AST_IMMEDIATE: assert property ($rose(serialLoad_n)
      && serState == tcpc_pkg::SER_SHIFT && bitCnt >= `TCPC_ADDR_BITS
      && addrSr == `TCPC_ADDR_HMASK |-> ##1 writeDone ##1 !writeDone)
      else $error("Write not applied at end of frame");
   AST_TRACK_PHASE: assert property (##1 dataClockPhase ==
      (data_clock_track_select ? `TCPC_FIXED_PHASE : out_phase_rise))
      else $error("Data clock phase does not follow track select");
   AST_OUT_FIELDS: assert property (commit
      && addrSr == `TCPC_ADDR_OUTPHASE |=> out_data_delay_sel == $past(dataSr[14:13])
      && data_clock_invert == $past(dataSr[15]))
      else $error("Output phase register not written");
   AST_UNMAPPED_WRITE: assert property (commit
      && (addrSr < `TCPC_ADDR_DRIVE_A || addrSr > `TCPC_ADDR_HMASK) |=>
      $stable(driveA) && $stable(outPhase) && $stable(hMask) && !writeDone)
      else $error("Unmapped write changed a register");
   AST_STABLE: assert property (!commit |=> $stable(cdsPhase)
      && $stable(outPhase))
      else $error("Register changed without a write");

   COV_HMASK_WRITE: cover property (commit && addrSr == `TCPC_ADDR_HMASK);
   COV_FIXED_PHASE: cover property (data_clock_track_select ##1 writeDone);
   COV_UNMAPPED:    cover property (commit && addrSr > `TCPC_ADDR_HMASK);
   COV_DRIVE_A:     cover property (commit && addrSr == `TCPC_ADDR_DRIVE_A);
   COV_SHORT_FRAME: cover property ($rose(serialLoad_n) && bitCnt < `TCPC_ADDR_BITS);

endmodule // tcpc_phase_config
`default_nettype wire

// *** test/tb.sv ***
// Self-checking testbench of the timing core phase configuration registers
`timescale 1ns/10ps
`default_nettype none

module tb;
   // ***************************************************************
   // Design hookup
   // ***************************************************************
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        serialLoad_n = 1'b1;
   logic        serialClock = 1'b0;
   logic        serialData = 1'b0;
   logic [2:0]  d1, d2, d3, d4, dl, drg, d5, d6, d7, d8, hmask;
   logic [5:0]  data_level_sample, reset_level_sample, shw, rise, fall, phase;
   logic [1:0]  dly;
   logic        track, inv, writeDone;
   logic [22:0] eA;
   logic [14:0] eB;
   logic [17:0] eC;
   logic [15:0] eD;
   logic [2:0]  eE;
   int          fails = 0;
   int          checked = 0;

   always #10 sys_clk = ~sys_clk;

   tcpc_phase_config dut_u
   (
      .sys_clk(sys_clk), .reset(reset), .serialLoad_n(serialLoad_n),
      .serialClock(serialClock), .serialData(serialData),
      .first_horiz_drive(d1), .second_horiz_drive(d2), .third_horiz_drive(d3),
      .fourth_horiz_drive(d4), .last_horiz_drive(dl), .reset_gate_drive(drg),
      .fifth_horiz_drive(d5), .sixth_horiz_drive(d6), .seventh_horiz_drive(d7),
      .eighth_horiz_drive(d8), .data_sample_edge_pos(data_level_sample),
      .reset_sample_edge_pos(reset_level_sample), .reset_sample_width(shw),
      .out_phase_rise(rise), .out_phase_fall(fall),
      .data_clock_track_select(track), .out_data_delay_sel(dly),
      .data_clock_invert(inv), .dataClockPhase(phase),
      .clamp_horiz_mask_en(hmask), .writeDone(writeDone)
   );

   // ***************************************************************
   // Checking tasks
   // ***************************************************************
   task check(input string name, input logic [27:0] seen, input logic [27:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task set_defaults;
      eA = 23'h111111;
      eB = 15'h1111;
      eC = 18'h0a500;
      eD = 16'h0500;
      eE = 3'h7;
   endtask

   task check_all;
      check("first", 28'(d1), 28'(eA[2:0]));
      check("second", 28'(d2), 28'(eA[6:4]));
      check("third", 28'(d3), 28'(eA[10:8]));
      check("fourth", 28'(d4), 28'(eA[14:12]));
      check("last", 28'(dl), 28'(eA[18:16]));
      check("gate", 28'(drg), 28'(eA[22:20]));
      check("fifth", 28'(d5), 28'(eB[2:0]));
      check("sixth", 28'(d6), 28'(eB[6:4]));
      check("seventh", 28'(d7), 28'(eB[10:8]));
      check("eighth", 28'(d8), 28'(eB[14:12]));
      check("dataEdge", 28'(data_level_sample), 28'(eC[5:0]));
      check("resetEdge", 28'(reset_level_sample), 28'(eC[11:6]));
      check("width", 28'(shw), 28'(eC[17:12]));
      check("rise", 28'(rise), 28'(eD[5:0]));
      check("fall", 28'(fall), 28'(eD[11:6]));
      check("track", 28'(track), 28'(eD[12]));
      check("phase", 28'(phase), eD[12] ? 28'h0 : 28'(eD[5:0]));
      check("delay", 28'(dly), 28'(eD[14:13]));
      check("invert", 28'(inv), 28'(eD[15]));
      check("mask", 28'(hmask), 28'(eE));
   endtask

   // Serial frame: address then data, both LSB first, nb bits in all
   task wr(input logic [7:0] a, input logic [27:0] d, input int nb, input logic ok);
      logic [35:0] bits;
      logic [27:0] dm;
      bits = {d, a};
      @(negedge sys_clk);
      serialLoad_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      for (int i = 0; i < nb; i++)
      begin
         serialData = bits[i];
         serialClock = 1'b1;
         @(negedge sys_clk);
         serialClock = 1'b0;
         @(negedge sys_clk);
      end
      // Still inside the frame: nothing applied yet
      check("earlyDone", 28'(writeDone), 28'h0);
      check_all();
      serialData = ~serialData;
      serialLoad_n = 1'b1;
      // Frame end seen at the next rising edge; new values stand right after it
      @(negedge sys_clk);
      check("writeDone", 28'(writeDone), 28'(ok));
      if (ok)
      begin
         dm = (nb >= 36) ? d : (d & ((28'h1 << (nb - 8)) - 28'h1));
         case (a)
            8'h35: eA = dm[22:0];
            8'h36: eB = dm[14:0];
            8'h37: eC = dm[17:0];
            8'h38: eD = dm[15:0];
            8'h39: eE = dm[2:0];
            default: ;
         endcase
      end
      check_all();
      @(negedge sys_clk);
      check("doneFall", 28'(writeDone), 28'h0);
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial
   begin
      logic [7:0] bad [6];
      logic [5:0] r;
      // Unmapped addresses only; the test ranges are never touched
      bad = '{8'h34, 8'h3a, 8'h3d, 8'h70, 8'h00, 8'hff};
      set_defaults();
      @(negedge sys_clk);
      check_all();
      check("resetDone", 28'(writeDone), 28'h0);
      repeat (3) @(negedge sys_clk);
      reset = 1'b0;
      wr(8'h35, 28'h0765432, 31, 1'b1);
      wr(8'h36, 28'h0006507, 23, 1'b1);
      wr(8'h37, 28'h002a07f, 26, 1'b1);
      // Short data part: unsent bits read as zero
      wr(8'h37, 28'h0ffffff, 14, 1'b1);
      for (int t = 0; t < 2; t++)
      begin
         for (int k = 0; k < 4; k++)
         begin
            r = 6'h05 + 6'(k);
            // Falling phase kept at rising plus 32
            wr(8'h38, {12'h0, 1'(k), 2'(k), 1'(t), r + 6'h20, r}, 24, 1'b1);
         end
      end
      wr(8'h39, 28'h0000002, 11, 1'b1);
      wr(8'h39, 28'hffffff5, 36, 1'b1);
      foreach (bad[i])
         wr(bad[i], 28'hfffffff, 36, 1'b0);
      wr(8'h39, 28'h0000000, 5, 1'b0);
      @(negedge sys_clk);
      reset = 1'b1;
      @(negedge sys_clk);
      set_defaults();
      check_all();
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      wr(8'h36, 28'h0000000, 23, 1'b1);
      summarize();
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      summarize();
   end
endmodule // tb

`default_nettype wire
